// ===== core/hetp_pkg.sv
package hetp_pkg;

	// ------------------------------------------------------------
	// Mode and configuration encodings
	// ------------------------------------------------------------
	localparam logic [2:0] HETP_MODE_XPARENT = 3'h4;
	localparam logic [1:0] HETP_ACCESS_COLL  = 2'h1;
	localparam int         HETP_SRA_BIT      = 4;

	// ------------------------------------------------------------
	// Serial frame layout
	// ------------------------------------------------------------
	localparam int         HETP_CNT_W    = 5;
	localparam logic [1:0] HETP_SLOT_B1  = 2'h0;
	localparam logic [1:0] HETP_SLOT_B2  = 2'h1;
	localparam logic [1:0] HETP_SLOT_D   = 2'h3;
	localparam logic [2:0] HETP_BIT_FIRST = 3'h0;
	localparam logic [2:0] HETP_BIT_LAST  = 3'h7;
	localparam int         HETP_CH_B1    = 0;
	localparam int         HETP_CH_B2    = 1;
	localparam int         HETP_CH_D     = 2;
	localparam logic [7:0] HETP_IDLE_BYTE = 8'hFF;

	// ------------------------------------------------------------
	// Controller interrupt status bit positions
	// ------------------------------------------------------------
	localparam int HETP_IRQ_W   = 4;
	localparam int HETP_IRQ_XPR = 0;
	localparam int HETP_IRQ_XDU = 1;
	localparam int HETP_IRQ_XMR = 2;
	localparam int HETP_IRQ_RFO = 3;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0]
	{
		TX_IDLE = 2'h0,
		TX_SEND = 2'h1
	} hetp_tx_state_t;

	typedef struct packed
	{
		logic [7:0] data;
		logic [1:0] slot;
	} hetp_word_t;

endpackage : hetp_pkg

// ===== core/hetp_core.sv
// Function
// - Transparent path operates only when controller mode field equals 100.
// - Transmit queue bytes go out unmodified, no flags, checksum or stuffing.
// - Transmission starts byte aligned in first enabled channel of next frame.
// - Transmit plus message end gives pool ready after last byte, then ones.
// - With collision mode 1 the stop/go bit acts as clear to send.
// - Stop during transmission raises message repeat only in collision mode 1.
// - Transmit queue running empty without message end raises underrun.
// - Repeat and underrun flush the queue; writes ignored until status read.
// - Reception starts byte aligned in first enabled channel of next frame.
// - Each received byte enters the receive status register, and the receive queue unless it is full.
// - Receive queue full with status append zero raises receive overflow.
// - Summary bit reports any unmasked controller interrupt to the host.
// - Writing one to a mask bit hides that controller source.
// - Test loop feeds transmit bits into receiver, ignoring incoming data.
// - Transceiver disable turns layer one off and makes clock pins inputs.
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Small word buffer
// ----------------------------------------------------------------
module hetp_buf
	import hetp_pkg::*;
#(
	parameter int W = 8,
	parameter int D = 2
)
(
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         flush,
	// Fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	localparam int PW = (D > 1) ? $clog2(D) : 1;
	localparam int CW = $clog2(D + 1);
	localparam logic [CW-1:0] FULL = CW'(D);
	localparam logic [PW-1:0] LAST = PW'(D - 1);

	logic [W-1:0]  mem_r [D];
	logic [PW-1:0] wp_r;
	logic [PW-1:0] rp_r;
	logic [CW-1:0] cnt_r;
	logic          push;
	logic          pop;

	// Handshakes follow the fill level.
	assign in_ready  = (cnt_r != FULL);
	assign out_valid = (cnt_r != '0);
	assign out_data  = mem_r[rp_r];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Pointers and level; flush empties the buffer.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end
		else if (flush)
		begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end
		else
		begin
			if (push)
				wp_r <= (wp_r == LAST) ? '0 : PW'(wp_r + 1'b1);
			if (pop)
				rp_r <= (rp_r == LAST) ? '0 : PW'(rp_r + 1'b1);
			cnt_r <= CW'(cnt_r + CW'(push) - CW'(pop));
		end
	end

	// Storage is written only, never reset.
	always_ff @(posedge clk)
	begin
		if (push)
			mem_r[wp_r] <= in_data;
	end

endmodule : hetp_buf

// ----------------------------------------------------------------
// Extended transparent path
// ----------------------------------------------------------------
module hetp_core
	import hetp_pkg::*;
#(
	parameter int DEPTH = 2
)
(
	// System clock and reset
	input  wire logic                  CLK,
	input  wire logic                  RESET,
	// Host transmit queue and commands
	input  wire logic [7:0]            TX_WDATA,
	input  wire logic                  TX_WVALID,
	output logic                       TX_WREADY,
	input  wire logic                  TRANSPARENT_TRANSMIT_CMD,
	input  wire logic                  MESSAGE_END_CMD,
	// Host receive queue
	output logic [7:0]                 RX_RDATA,
	output logic                       RX_RVALID,
	input  wire logic                  RX_RREADY,
	output logic [7:0]                 RECEIVE_STATUS_REG,
	// Configuration
	input  wire logic [2:0]            CONTROLLER_MODE_FIELD,
	input  wire logic [1:0]            ACCESS_MODE_FIELD,
	input  wire logic [7:0]            EXTENDED_MODE_REG,
	input  wire logic [2:0]            CHANNEL_ENABLE_REG,
	input  wire logic                  TEST_LOOP_BIT,
	input  wire logic                  TRANSCEIVER_DISABLE_BIT,
	// Interrupt status
	input  wire logic [HETP_IRQ_W-1:0] CONTROLLER_INTERRUPT_MASK,
	input  wire logic                  CONTROLLER_STATUS_READ,
	output logic [HETP_IRQ_W-1:0]      CONTROLLER_INTERRUPT_STATUS,
	output logic                       TOP_INTERRUPT_STATUS,
	// Serial link
	input  wire logic                  SERIAL_DATA_CLOCK,
	input  wire logic                  FRAME_SYNC,
	input  wire logic                  DOWNSTREAM_SERIAL_DATA,
	output logic                       UPSTREAM_SERIAL_DATA,
	input  wire logic                  STOP_GO,
	// Layer one control
	output logic                       LAYER1_ENABLE,
	output logic                       CLOCK_PINS_OE
);
	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	hetp_tx_state_t        state_r;
	logic                  xme_r, lock_r, req_r;
	logic [7:0]            mb_data_r;
	logic [HETP_IRQ_W-1:0] irq_r, irq_set;
	logic [2:0]            ev_m, ev_s, ev_q;
	logic                  stop_m, stop_s;
	logic                  xmode, coll, busy, ack_evt, starve_evt, rx_evt;
	logic                  q_valid, q_ready, q_pop, flush, tx_err;
	logic [7:0]            q_data;
	logic                  rq_ready;
	hetp_word_t            rx_word;
	logic                  l_rst_m, l_rst;
	logic [5:0]            cfg_m, cfg_s;
	logic                  fsc_m, fsc_s, fsc_q, dd_m, dd_s;
	logic                  req_m, req_s;
	logic [HETP_CNT_W-1:0] cnt_r, cur;
	logic                  l_act_r, l_rxon_r, ack_r, starve_r, rx_tgl_r;
	logic [7:0]            sh_r, rx_sh_r;
	hetp_word_t            rx_hold_r;
	logic                  frame_start, l_run, slot_en, load, tx_bit, rx_bit;
	logic [1:0]            slot;
	logic [2:0]            bpos;

	assign xmode = (CONTROLLER_MODE_FIELD == HETP_MODE_XPARENT);
	assign coll  = (ACCESS_MODE_FIELD == HETP_ACCESS_COLL);

	// ------------------------------------------------------------
	// Crossings into the system clock domain
	// ------------------------------------------------------------
	// Toggle events from the link and the stop/go level, two flops each.
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			ev_m   <= '0;
			ev_s   <= '0;
			ev_q   <= '0;
			stop_m <= 1'b0;
			stop_s <= 1'b0;
		end
		else
		begin
			ev_m   <= {rx_tgl_r, starve_r, ack_r};
			ev_s   <= ev_m;
			ev_q   <= ev_s;
			stop_m <= STOP_GO;
			stop_s <= stop_m;
		end
	end

	assign ack_evt    = ev_s[0] ^ ev_q[0];
	assign starve_evt = ev_s[1] ^ ev_q[1];
	assign rx_evt     = ev_s[2] ^ ev_q[2];
	assign busy       = req_r ^ ev_s[0];

	// ------------------------------------------------------------
	// Transmit queue and mailbox toward the link
	// ------------------------------------------------------------
	assign TX_WREADY = q_ready & ~lock_r & xmode;
	assign q_pop     = (state_r == TX_SEND) & ~busy & ~ack_evt & q_valid;
	assign tx_err    = irq_set[HETP_IRQ_XDU] | irq_set[HETP_IRQ_XMR];
	assign flush     = tx_err;

	hetp_buf #(.W(8), .D(DEPTH)) u_txq
	(
		.clk       (CLK),
		.rst       (RESET),
		.flush     (flush),
		.in_valid  (TX_WVALID & TX_WREADY),
		.in_ready  (q_ready),
		.in_data   (TX_WDATA),
		.out_valid (q_valid),
		.out_ready (q_pop),
		.out_data  (q_data)
	);

	// Mailbox holds one byte stable until the link acknowledges it.
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			mb_data_r <= HETP_IDLE_BYTE;
			req_r     <= 1'b0;
		end
		else if (q_pop)
		begin
			mb_data_r <= q_data;
			req_r     <= ~req_r;
		end
	end

	// ------------------------------------------------------------
	// Transmit control and interrupt causes
	// ------------------------------------------------------------
	// Command, completion and error handling of the transmitter.
	always_comb
	begin
		irq_set = '0;
		if (state_r == TX_IDLE)
			irq_set[HETP_IRQ_XPR] = xmode & TRANSPARENT_TRANSMIT_CMD &
				~MESSAGE_END_CMD;
		else if (!xmode)
			irq_set = '0;
		else if (coll && stop_s)
			irq_set[HETP_IRQ_XMR] = 1'b1;
		else if (xme_r && !q_valid && !busy)
			irq_set[HETP_IRQ_XPR] = 1'b1;
		else if (starve_evt && !xme_r && !q_valid)
			irq_set[HETP_IRQ_XDU] = 1'b1;
		else
			irq_set[HETP_IRQ_XPR] = TRANSPARENT_TRANSMIT_CMD &
				~MESSAGE_END_CMD;
		if (rx_evt && !rq_ready && !EXTENDED_MODE_REG[HETP_SRA_BIT])
			irq_set[HETP_IRQ_RFO] = 1'b1;
	end

	// Transmitter state: armed by a command, ended by completion or error.
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			state_r <= TX_IDLE;
			xme_r   <= 1'b0;
		end
		else
		begin
			case (state_r)
				TX_IDLE:
				begin
					if (xmode && TRANSPARENT_TRANSMIT_CMD)
					begin
						state_r <= TX_SEND;
						xme_r   <= MESSAGE_END_CMD;
					end
				end
				TX_SEND:
				begin
					if (TRANSPARENT_TRANSMIT_CMD && MESSAGE_END_CMD)
						xme_r <= 1'b1;
					if (!xmode || tx_err || irq_set[HETP_IRQ_XPR] && xme_r)
						state_r <= TX_IDLE;
				end
				default:
					state_r <= TX_IDLE;
			endcase
		end
	end

	// Sticky status, cleared by a read; a new event beats the clear.
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			irq_r  <= '0;
			lock_r <= 1'b0;
		end
		else
		begin
			irq_r  <= (irq_r & ~{HETP_IRQ_W{CONTROLLER_STATUS_READ}}) |
				irq_set;
			lock_r <= tx_err | (lock_r & ~CONTROLLER_STATUS_READ);
		end
	end

	assign CONTROLLER_INTERRUPT_STATUS = irq_r;
	assign TOP_INTERRUPT_STATUS =
		|(irq_r & ~CONTROLLER_INTERRUPT_MASK);

	// ------------------------------------------------------------
	// Receive queue and status byte
	// ------------------------------------------------------------
	hetp_buf #(.W(8), .D(DEPTH)) u_rxq
	(
		.clk       (CLK),
		.rst       (RESET),
		.flush     (1'b0),
		.in_valid  (rx_evt),
		.in_ready  (rq_ready),
		.in_data   (rx_word.data),
		.out_valid (RX_RVALID),
		.out_ready (RX_RREADY),
		.out_data  (RX_RDATA)
	);

	assign rx_word = rx_hold_r;

	// The last received byte is also shown as a status byte.
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
			RECEIVE_STATUS_REG <= '0;
		else if (rx_evt)
			RECEIVE_STATUS_REG <= rx_word.data;
	end

	// Layer one shut down, clock pins turned to inputs.
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			LAYER1_ENABLE <= 1'b0;
			CLOCK_PINS_OE <= 1'b0;
		end
		else
		begin
			LAYER1_ENABLE <= ~TRANSCEIVER_DISABLE_BIT;
			CLOCK_PINS_OE <= ~TRANSCEIVER_DISABLE_BIT;
		end
	end

	// ------------------------------------------------------------
	// Link domain
	// ------------------------------------------------------------
	// Reset release synchronised to the link clock.
	always_ff @(posedge SERIAL_DATA_CLOCK or posedge RESET)
	begin
		if (RESET)
		begin
			l_rst_m <= 1'b1;
			l_rst   <= 1'b1;
		end
		else
		begin
			l_rst_m <= 1'b0;
			l_rst   <= l_rst_m;
		end
	end

	// Pins and control levels pass two flops before use.
	always_ff @(posedge SERIAL_DATA_CLOCK or posedge l_rst)
	begin
		if (l_rst)
		begin
			cfg_m <= '0;
			cfg_s <= '0;
			fsc_m <= 1'b0;
			fsc_s <= 1'b0;
			fsc_q <= 1'b0;
			dd_m  <= 1'b1;
			dd_s  <= 1'b1;
			req_m <= 1'b0;
			req_s <= 1'b0;
		end
		else
		begin
			cfg_m <= {CHANNEL_ENABLE_REG, TEST_LOOP_BIT, xmode,
				state_r == TX_SEND};
			cfg_s <= cfg_m;
			fsc_m <= FRAME_SYNC;
			fsc_s <= fsc_m;
			fsc_q <= fsc_s;
			dd_m  <= DOWNSTREAM_SERIAL_DATA;
			dd_s  <= dd_m;
			req_m <= req_r;
			req_s <= req_m;
		end
	end

	// Frame position and enabled slot decode.
	assign frame_start = fsc_s & ~fsc_q;
	assign cur  = frame_start ? '0 : cnt_r;
	assign slot = cur[4:3];
	assign bpos = cur[2:0];
	always_comb
	begin
		case (slot)
			HETP_SLOT_B1: slot_en = cfg_s[3 + HETP_CH_B1];
			HETP_SLOT_B2: slot_en = cfg_s[3 + HETP_CH_B2];
			HETP_SLOT_D:  slot_en = cfg_s[3 + HETP_CH_D];
			default:      slot_en = 1'b0;
		endcase
	end

	assign l_run  = l_act_r | (frame_start & cfg_s[0]);
	assign load   = l_run & slot_en & (bpos == HETP_BIT_FIRST) &
		(req_s ^ ack_r);
	assign tx_bit = (bpos == HETP_BIT_FIRST) ?
		(load ? mb_data_r[7] : 1'b1) : sh_r[7];
	assign rx_bit = cfg_s[2] ? tx_bit : dd_s;

	// Transmit shifter, MSB first, ones outside loaded bytes.
	always_ff @(posedge SERIAL_DATA_CLOCK or posedge l_rst)
	begin
		if (l_rst)
		begin
			cnt_r    <= '0;
			l_act_r  <= 1'b0;
			sh_r     <= HETP_IDLE_BYTE;
			ack_r    <= 1'b0;
			starve_r <= 1'b0;
			UPSTREAM_SERIAL_DATA <= 1'b1;
		end
		else
		begin
			cnt_r   <= HETP_CNT_W'(cur + 1'b1);
			l_act_r <= cfg_s[0] & (l_act_r | frame_start);
			if (bpos == HETP_BIT_FIRST && slot_en && load)
				sh_r <= {mb_data_r[6:0], 1'b1};
			else if (bpos == HETP_BIT_FIRST)
				sh_r <= HETP_IDLE_BYTE;
			else
				sh_r <= {sh_r[6:0], 1'b1};
			if (load)
				ack_r <= ~ack_r;
			if (l_run && slot_en && bpos == HETP_BIT_FIRST && !load)
				starve_r <= ~starve_r;
			UPSTREAM_SERIAL_DATA <= tx_bit;
		end
	end

	// Receive shifter; starts on the frame after the mode is on.
	always_ff @(posedge SERIAL_DATA_CLOCK or posedge l_rst)
	begin
		if (l_rst)
		begin
			l_rxon_r  <= 1'b0;
			rx_sh_r   <= '0;
			rx_hold_r <= '0;
			rx_tgl_r  <= 1'b0;
		end
		else
		begin
			l_rxon_r <= cfg_s[1] & (l_rxon_r | frame_start);
			if ((l_rxon_r || frame_start && cfg_s[1]) && slot_en)
			begin
				rx_sh_r <= {rx_sh_r[6:0], rx_bit};
				if (bpos == HETP_BIT_LAST)
				begin
					rx_hold_r <= '{data: {rx_sh_r[6:0], rx_bit},
						slot: slot};
					rx_tgl_r  <= ~rx_tgl_r;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	// A byte handed over before the transmitter went idle still finishes
	// shifting, so idle ones are only promised from a slot's first bit on.
	chk_mode_gate: assert property (@(posedge CLK) disable iff (RESET)
		!xmode |=> state_r == TX_IDLE)
		else $error("transmitter active outside transparent mode");
	chk_repeat_stop: assert property (@(posedge CLK) disable iff (RESET)
		state_r == TX_SEND && xmode && coll && stop_s
		|=> irq_r[HETP_IRQ_XMR] && state_r == TX_IDLE)
		else $error("stop during send gave no message repeat");
	chk_underrun_flush: assert property (@(posedge CLK) disable iff (RESET)
		irq_set[HETP_IRQ_XDU] |=> !q_valid && lock_r)
		else $error("underrun did not flush and lock queue");
	chk_lock_writes: assert property (@(posedge CLK) disable iff (RESET)
		lock_r |-> !TX_WREADY)
		else $error("queue accepted a write while locked");
	chk_rx_status: assert property (@(posedge CLK) disable iff (RESET)
		rx_evt |=> RECEIVE_STATUS_REG == $past(rx_word.data))
		else $error("status byte differs from received byte");
	chk_rx_overflow: assert property (@(posedge CLK) disable iff (RESET)
		rx_evt && !rq_ready && !EXTENDED_MODE_REG[HETP_SRA_BIT]
		|=> irq_r[HETP_IRQ_RFO])
		else $error("full receive queue gave no overflow");
	chk_summary_set: assert property (@(posedge CLK) disable iff (RESET)
		irq_set[HETP_IRQ_XPR] && !CONTROLLER_INTERRUPT_MASK[HETP_IRQ_XPR]
		##1 !CONTROLLER_STATUS_READ |=> TOP_INTERRUPT_STATUS)
		else $error("pending pool ready lost from summary");
	chk_mask_hides: assert property (@(posedge CLK) disable iff (RESET)
		CONTROLLER_INTERRUPT_MASK == '1 |-> !TOP_INTERRUPT_STATUS)
		else $error("masked source reached summary");
	chk_l1_off: assert property (@(posedge CLK) disable iff (RESET)
		TRANSCEIVER_DISABLE_BIT [*2] |-> !CLOCK_PINS_OE && !LAYER1_ENABLE)
		else $error("layer one still on after disable");
	chk_idle_ones: assert property
		(@(posedge SERIAL_DATA_CLOCK) disable iff (l_rst)
		!l_run && bpos == HETP_BIT_FIRST |=> UPSTREAM_SERIAL_DATA)
		else $error("idle transmitter not sending ones");
	chk_frame_align: assert property
		(@(posedge SERIAL_DATA_CLOCK) disable iff (l_rst)
		!l_act_r ##1 l_act_r |-> $past(frame_start))
		else $error("transmission started off frame start");
	chk_loop_path: assert property
		(@(posedge SERIAL_DATA_CLOCK) disable iff (l_rst)
		cfg_s[2] |-> rx_bit == tx_bit)
		else $error("test loop not feeding transmit bits back");
	cov_underrun: cover property (@(posedge CLK) disable iff (RESET)
		irq_set[HETP_IRQ_XDU]);
	cov_repeat: cover property (@(posedge CLK) disable iff (RESET)
		irq_set[HETP_IRQ_XMR]);
	cov_msg_end: cover property (@(posedge CLK) disable iff (RESET)
		state_r == TX_SEND && xme_r ##1 state_r == TX_IDLE);
	cov_overflow: cover property (@(posedge CLK) disable iff (RESET)
		irq_set[HETP_IRQ_RFO]);

endmodule : hetp_core

`default_nettype wire

// ===== bench/hetp_link_model.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------
// Serial frame partner
// ------------------------------------------------------------
module hetp_link_model
	import hetp_pkg::*;
(
	// Link pins
	output logic            serial_data_clock,
	output logic            frame_sync,
	output logic            dd,
	output logic            stop_go,
	// Test control
	input  wire logic [7:0] pattern,
	input  wire logic       stop_req
);
	logic [4:0] bit_cnt = 5'h00;

	// The data clock runs free, since the frame timing depends on it.
	initial serial_data_clock = 1'b0;
	always #15 serial_data_clock = ~serial_data_clock;

	// Frame sync on bit zero; B1 carries the pattern, MSB first.
	// Slots other than B1 get a toggling bit, never a stale one.
	initial
	begin
		frame_sync     = 1'b0;
		dd      = 1'b1;
		stop_go = 1'b0;
	end
	always @(posedge serial_data_clock)
	begin
		frame_sync     <= (bit_cnt == 5'h00);
		dd      <= (bit_cnt[4:3] == HETP_SLOT_B1) ?
			pattern[3'h7 - bit_cnt[2:0]] : bit_cnt[0];
		stop_go <= stop_req;
		bit_cnt <= bit_cnt + 5'h01;
	end
endmodule : hetp_link_model

`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------
// Testbench top
// ------------------------------------------------------------
module tb
	import hetp_pkg::*;
;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic [7:0] tx_wdata, rx_rdata, rsr, extended_mode_reg, pattern;
	logic       tx_wvalid, tx_wready, tx_cmd, me_cmd, rx_rvalid, rx_rready;
	logic [2:0] mode, chen;
	logic [1:0] acc;
	logic       test_loop_bit, dis, sread, top, du, l1en, ckoe, stop_req, ones;
	logic [3:0] mask, stat;
	wire        serial_data_clock, frame_sync, dd, stop_go;
	int         err_count, tests_run, seed, n;
	logic [7:0] rxq[$], got[$], exp_q[$];

	// System clock, 100 ns period.
	always #50 clk = ~clk;

	hetp_core #(.DEPTH(2)) u_dut (
		.CLK(clk), .RESET(rst), .TX_WDATA(tx_wdata), .TX_WVALID(tx_wvalid),
		.TX_WREADY(tx_wready), .TRANSPARENT_TRANSMIT_CMD(tx_cmd),
		.MESSAGE_END_CMD(me_cmd), .RX_RDATA(rx_rdata), .RX_RVALID(rx_rvalid),
		.RX_RREADY(rx_rready), .RECEIVE_STATUS_REG(rsr),
		.CONTROLLER_MODE_FIELD(mode), .ACCESS_MODE_FIELD(acc),
		.EXTENDED_MODE_REG(extended_mode_reg), .CHANNEL_ENABLE_REG(chen),
		.TEST_LOOP_BIT(test_loop_bit), .TRANSCEIVER_DISABLE_BIT(dis),
		.CONTROLLER_INTERRUPT_MASK(mask), .CONTROLLER_STATUS_READ(sread),
		.CONTROLLER_INTERRUPT_STATUS(stat), .TOP_INTERRUPT_STATUS(top),
		.SERIAL_DATA_CLOCK(serial_data_clock), .FRAME_SYNC(frame_sync),
		.DOWNSTREAM_SERIAL_DATA(dd), .UPSTREAM_SERIAL_DATA(du),
		.STOP_GO(stop_go), .LAYER1_ENABLE(l1en), .CLOCK_PINS_OE(ckoe));

	hetp_link_model u_link (.serial_data_clock(serial_data_clock), .frame_sync(frame_sync), .dd(dd), .stop_go(stop_go),
		.pattern(pattern), .stop_req(stop_req));

	// Keep every byte popped from the receive queue, sampled once settled.
	always @(negedge clk)
		if (rx_rvalid === 1'b1 && rx_rready === 1'b1)
			rxq.push_back(rx_rdata);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic exp_top(input logic [3:0] st, input logic [3:0] mk);
		return |(st & ~mk);
	endfunction : exp_top

	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_of_test

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic tick(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask : tick

	task automatic guard(input string nm);
		if (n >= 400)
		begin
			err_count++;
			$display("[ERR] %s expected done seen timeout", nm);
			end_of_test();
		end
	endtask : guard

	task automatic wait_irq(input int b);
		for (n = 0; stat[b] !== 1'b1 && n < 400; n++)
			tick(1);
		guard("status wait");
	endtask : wait_irq

	// Offer a byte and hold it until the queue takes it.
	task automatic put_byte(input logic [7:0] d);
		tx_wdata  = d;
		tx_wvalid = 1'b1;
		for (n = 0; tx_wready !== 1'b1 && n < 400; n++)
			tick(1);
		tick(1);
		tx_wvalid = 1'b0;
		tick(1);
		guard("queue write");
	endtask : put_byte

	task automatic cmd(input logic me);
		tx_cmd = 1'b1;
		me_cmd = me;
		tick(1);
		tx_cmd = 1'b0;
		me_cmd = 1'b0;
	endtask : cmd

	task automatic read_stat();
		sread = 1'b1;
		tick(1);
		sread = 1'b0;
	endtask : read_stat

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		seed = 63;
		err_count = 0;
		tests_run = 0;
		tx_wdata = 8'h00;
		{tx_wvalid, tx_cmd, me_cmd, test_loop_bit, dis, sread, stop_req} = 7'h00;
		rx_rready = 1'b1;
		mode = HETP_MODE_XPARENT;
		acc = 2'h0;
		extended_mode_reg = 8'h00;
		chen = 3'h1;
		mask = 4'h0;
		pattern = 8'h00;
		repeat (6) @(posedge clk);
		#1 rst = 1'b0;
		tick(4);

		// Layer one switched off and back on.
		dis = 1'b1;
		tick(3);
		chk("layer1 on", 8'h00, {7'h00, l1en});
		chk("clock oe", 8'h00, {7'h00, ckoe});
		dis = 1'b0;
		tick(3);
		chk("clock oe", 8'h01, {7'h00, ckoe});

		// Reception of a fixed corner byte, then random ones.
		for (int i = 0; i < 3; i++)
		begin
			pattern = (i == 0) ? 8'h81 : 8'($random(seed));
			tick(40);
			rxq.delete();
			tick(40);
			chk("rx seen", 8'h01, {7'h00, rxq.size() > 0});
			foreach (rxq[j])
				chk("rx byte", pattern, rxq[j]);
			chk("rx status", pattern, rsr);
		end

		// Test loop: four bytes sent in two blocks come back unchanged.
		test_loop_bit = 1'b1;
		pattern = 8'h00;
		exp_q.delete();
		repeat (4)
			exp_q.push_back(8'h01 | (8'($random(seed)) & 8'h7E));
		tick(40);
		read_stat();
		rxq.delete();
		put_byte(exp_q[0]);
		put_byte(exp_q[1]);
		cmd(1'b0);
		wait_irq(HETP_IRQ_XPR);
		read_stat();
		put_byte(exp_q[2]);
		put_byte(exp_q[3]);
		cmd(1'b1);
		wait_irq(HETP_IRQ_XPR);
		read_stat();
		tick(60);
		got.delete();
		foreach (rxq[j])
			if (rxq[j] !== HETP_IDLE_BYTE)
				got.push_back(rxq[j]);
		chk("loop count", 8'h04, 8'(got.size()));
		foreach (exp_q[j])
			chk("loop byte", exp_q[j], (j < got.size()) ? got[j] : 8'hXX);

		// Underrun locks the queue; mask and summary follow the status.
		test_loop_bit = 1'b0;
		tick(20);
		read_stat();
		put_byte(8'h00);
		cmd(1'b0);
		wait_irq(HETP_IRQ_XDU);
		chk("status", 8'h03, {4'h0, stat});
		chk("write lock", 8'h00, {7'h00, tx_wready});
		mask = 4'hF;
		tick(1);
		chk("summary", {7'h00, exp_top(4'h3, mask)}, {7'h00, top});
		mask = 4'hD;
		tick(1);
		chk("summary", {7'h00, exp_top(4'h3, mask)}, {7'h00, top});
		ones = 1'b1;
		repeat (40)
		begin
			tick(1);
			ones &= du;
		end
		chk("idle line", 8'h01, {7'h00, ones});
		read_stat();
		chk("status", 8'h00, {4'h0, stat});
		chk("summary", 8'h00, {7'h00, top});
		chk("write lock", 8'h01, {7'h00, tx_wready});
		mask = 4'h0;

		// Stop during sending gives message repeat and a lock.
		acc = HETP_ACCESS_COLL;
		put_byte(8'h00);
		put_byte(8'h00);
		cmd(1'b1);
		for (n = 0; du !== 1'b0 && n < 400; n++)
			tick(1);
		guard("tx start");
		stop_req = 1'b1;
		wait_irq(HETP_IRQ_XMR);
		tx_wvalid = 1'b1;
		tick(3);
		chk("write lock", 8'h00, {7'h00, tx_wready});
		tx_wvalid = 1'b0;
		stop_req = 1'b0;
		read_stat();
		chk("write lock", 8'h01, {7'h00, tx_wready});
		acc = 2'h0;

		// Receive queue left full overflows.
		pattern = 8'($random(seed));
		rx_rready = 1'b0;
		tick(2);
		read_stat();
		tick(60);
		chk("overflow", 8'h01, {7'h00, stat[HETP_IRQ_RFO]});
		rx_rready = 1'b1;
		tick(2);
		read_stat();

		// Controller mode 000 refuses writes and commands.
		mode = 3'h0;
		tick(2);
		chk("mode ready", 8'h00, {7'h00, tx_wready});
		cmd(1'b0);
		tick(3);
		chk("mode cmd", 8'h00, {7'h00, stat[HETP_IRQ_XPR]});
		mode = HETP_MODE_XPARENT;
		tick(2);
		end_of_test();
	end
endmodule : tb

`default_nettype wire
